/* File: sprl_pkg.sv */
// sprl_pkg: shared constants and types for the serial port lockup recovery block
// assumes: 32-bit axi4-lite register access, single clock domain
package sprl_pkg;
	// ==========================================
	// register byte offsets
	localparam logic [7:0] ADDR_PIS = 8'h00;
	localparam logic [7:0] ADDR_PIS_CLR = 8'h04;
	localparam logic [7:0] ADDR_PIS_EN = 8'h08;
	localparam logic [7:0] ADDR_TFD = 8'h0C;
	localparam logic [7:0] ADDR_SERR = 8'h10;
	localparam logic [7:0] ADDR_SCTL = 8'h14;
	localparam logic [7:0] ADDR_STAT = 8'h18;
	// ==========================================
	// field positions
	localparam int PSS_BIT = 1;
	localparam int IFS_BIT = 27;
	localparam int OVF_BIT = 2;
	localparam int LSE_BIT = 23;
	localparam int BSY_BIT = 7;
	localparam int DRQ_BIT = 3;
	localparam logic [3:0] DET_COMRESET = 4'h1;
	localparam logic [3:0] DET_IDLE = 4'h0;
	// ==========================================
	// sizes and bus answers
	localparam int RX_DEPTH = 8;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	// ==========================================
	// link-side events from the receive path
	typedef struct packed {
		logic pio_setup;
		logic pio_write;
		logic sync_escape;
		logic cont_corrupt;
		logic reg_word;
		logic reg_end;
	} sprl_rx_ev_t;
	typedef enum logic [1:0] {SPRL_RUN, SPRL_STALL_PIO, SPRL_STALL_LINK, SPRL_STALL_OVF} sprl_state_t;
endpackage

/* File: sprl_rx_buf.sv */
// sprl_rx_buf: receive word buffer for device-to-host register frames
// assumes: writer and reader on aclk; read data registered
`timescale 1ns/10ps
module sprl_rx_buf #(
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	input wire logic aclk,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [31:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [31:0] rd_data
);
	logic [31:0] mem [DEPTH];
	always_ff @(posedge aclk)
	begin
		if (ce && wr_en)
			mem[wr_addr] <= wr_data;
	end
	always_ff @(posedge aclk)
	begin
		if (ce)
			rd_data <= mem[rd_addr];
	end
endmodule

/* File: sprl_port.sv */
// sprl_port: port lockup logic with axi4-lite registers and interrupt
// assumes: rx events from logic on aclk; tfd status from a pin, synchronised here
// How it works
// - pio write setup with busy,drq clear stalls
// - setup sets flag; stall cleared by port reset
// - link lockup sets fatal and sequence error flags
// - sync escape locks link; soft reset useless
// - corrupt continue primitive locks link too
// - register frame over eight words overflows, locks
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/10ps
module sprl_port
#(
	parameter int RX_WORDS = sprl_pkg::RX_DEPTH
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire sprl_pkg::sprl_rx_ev_t rx_ev,
	input wire logic [31:0] rx_word,
	input wire logic soft_reset_seen,
	input wire logic drive_busy_bit,
	input wire logic drive_data_request_bit,
	output logic comreset_r,
	output logic port_stalled_r,
	output logic irq_r
);
	import sprl_pkg::*;
	// ==========================================
	// pin synchronisers
	logic [1:0] bsy_s_r, drq_s_r;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bsy_s_r <= 2'b00;
			drq_s_r <= 2'b00;
		end
		else if (ce)
		begin
			bsy_s_r <= {bsy_s_r[0], drive_busy_bit};
			drq_s_r <= {drq_s_r[0], drive_data_request_bit};
		end
	end
	wire logic bsy = bsy_s_r[1];
	wire logic drq = drq_s_r[1];
	// ==========================================
	// lockup state machine
	sprl_state_t st_r, st_nxt;
	logic [3:0] det_r;
	logic [3:0] rx_cnt_r;
	logic pio_hit, link_hit, ovf_hit, port_rst;
	assign port_rst = (det_r == DET_COMRESET);
	assign pio_hit = rx_ev.pio_setup && rx_ev.pio_write && !bsy && !drq;
	assign link_hit = rx_ev.sync_escape || rx_ev.cont_corrupt;
	assign ovf_hit = rx_ev.reg_word && (rx_cnt_r == 4'(RX_WORDS));
	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			SPRL_RUN:
				if (link_hit)
					st_nxt = SPRL_STALL_LINK;
				else if (ovf_hit)
					st_nxt = SPRL_STALL_OVF;
				else if (pio_hit)
					st_nxt = SPRL_STALL_PIO;
			SPRL_STALL_PIO, SPRL_STALL_LINK, SPRL_STALL_OVF:
				st_nxt = st_r; // soft reset frames cannot release any stall
			default:
				st_nxt = SPRL_RUN;
		endcase
		if (port_rst)
			st_nxt = SPRL_RUN;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_r <= SPRL_RUN;
		else if (ce)
			st_r <= st_nxt;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			port_stalled_r <= 1'b0;
		else if (ce)
			port_stalled_r <= (st_nxt != SPRL_RUN);
	end
	// ==========================================
	// receive buffer and frame word count
	logic [31:0] rx_rd_data;
	logic [2:0] rx_rd_idx_r;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rx_cnt_r <= 4'h0;
		else if (ce)
		begin
			if (port_rst || rx_ev.reg_end)
				rx_cnt_r <= 4'h0;
			else if (rx_ev.reg_word && rx_cnt_r != 4'(RX_WORDS))
				rx_cnt_r <= rx_cnt_r + 4'h1;
		end
	end
	sprl_rx_buf #(.DEPTH(RX_DEPTH), .AW(3)) u_buf (
		.aclk(aclk),
		.ce(ce),
		.wr_en(rx_ev.reg_word && rx_cnt_r != 4'(RX_WORDS)),
		.wr_addr(rx_cnt_r[2:0]),
		.wr_data(rx_word),
		.rd_addr(rx_rd_idx_r),
		.rd_data(rx_rd_data)
	);
	// ==========================================
	// interrupt status, sticky; set beats clear
	logic [31:0] pis_r, pis_en_r, serr_r, pis_set, clr_w, wd_r;
	logic wr_go;
	logic [7:0] aw_r;
	always_comb
	begin
		pis_set = ZERO32;
		pis_set[PSS_BIT] = rx_ev.pio_setup;
		pis_set[IFS_BIT] = link_hit && st_r == SPRL_RUN;
		pis_set[OVF_BIT] = ovf_hit && st_r == SPRL_RUN;
		clr_w = (wr_go && aw_r == ADDR_PIS_CLR) ? wd_r : ZERO32;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pis_r <= ZERO32;
		else if (ce)
			pis_r <= (pis_r & ~clr_w) | pis_set;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			serr_r <= ZERO32;
		else if (ce)
		begin
			if (wr_go && aw_r == ADDR_SERR)
				serr_r <= serr_r & ~wd_r;
			if (link_hit)
				serr_r[LSE_BIT] <= 1'b1; // set beats clear
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq_r <= 1'b0;
		else if (ce)
			irq_r <= |(((pis_r & ~clr_w) | pis_set) & pis_en_r);
	end
	// ==========================================
	// axi4-lite write channel
	// ready flops keep outputs registered; the bus must idle while ce is low
	assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_r <= 8'h00;
			wd_r <= ZERO32;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				s_axi_awready <= 1'b0;
				aw_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				s_axi_wready <= 1'b0;
				wd_r <= s_axi_wdata;
			end
			if (wr_go)
			begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_r > ADDR_STAT || aw_r[1:0] != 2'b00) ? RESP_SLVERR : RESP_OKAY;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pis_en_r <= ZERO32;
			det_r <= DET_IDLE;
			comreset_r <= 1'b0;
		end
		else if (ce)
		begin
			if (wr_go && aw_r == ADDR_PIS_EN)
				pis_en_r <= wd_r;
			if (wr_go && aw_r == ADDR_SCTL)
				det_r <= wd_r[3:0];
			comreset_r <= port_rst;
		end
	end
	// ==========================================
	// axi4-lite read channel
	logic [31:0] rd_mux;
	always_comb
	begin
		case (s_axi_araddr)
			ADDR_PIS: rd_mux = pis_r;
			ADDR_PIS_EN: rd_mux = pis_en_r;
			ADDR_TFD: rd_mux = {24'h00_0000, bsy, 3'b000, drq, 3'b000};
			ADDR_SERR: rd_mux = serr_r;
			ADDR_SCTL: rd_mux = {28'h000_0000, det_r};
			ADDR_STAT: rd_mux = {26'h000_0000, soft_reset_seen, rx_cnt_r[2:0], 2'(st_r)};
			default: rd_mux = ZERO32;
		endcase
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= ZERO32;
			s_axi_rresp <= RESP_OKAY;
			rx_rd_idx_r <= 3'h0;
		end
		else if (ce)
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= (s_axi_araddr > ADDR_STAT || s_axi_araddr[1:0] != 2'b00)
					? RESP_SLVERR : RESP_OKAY;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			rx_rd_idx_r <= rx_rd_data[2:0] ^ rx_rd_idx_r;
			s_axi_arready <= (s_axi_rvalid && s_axi_rready) || (s_axi_arready && !s_axi_arvalid);
		end
	end
	// ==========================================
	// checks
	stall_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && st_r != SPRL_RUN && !port_rst |=> st_r == $past(st_r))
		else $error("stall released without port reset");
	pio_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && st_r == SPRL_RUN && pio_hit && !link_hit && !ovf_hit && !port_rst
		|=> st_r == SPRL_STALL_PIO)
		else $error("pio setup did not stall");
	pss_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && rx_ev.pio_setup |=> pis_r[PSS_BIT])
		else $error("pio setup flag not set");
	link_flags_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && link_hit && st_r == SPRL_RUN |=> pis_r[IFS_BIT] && serr_r[LSE_BIT])
		else $error("link lockup flags missing");
	esc_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && rx_ev.sync_escape && st_r == SPRL_RUN && !port_rst |=> st_r == SPRL_STALL_LINK)
		else $error("sync escape did not lock");
	cont_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && rx_ev.cont_corrupt && st_r == SPRL_RUN && !port_rst |=> st_r == SPRL_STALL_LINK)
		else $error("continue corruption did not lock");
	ovf_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && ovf_hit && !link_hit && st_r == SPRL_RUN && !port_rst |=> st_r == SPRL_STALL_OVF)
		else $error("overflow did not lock");
	comreset_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && port_rst |=> comreset_r && st_r == SPRL_RUN)
		else $error("comreset not driven");
endmodule

/* File: sprl_drive_model.sv */
// sprl_drive_model: behavioural serial drive on the far side of the port
// assumes: the port samples link events on rising aclk
`timescale 1ns/10ps
module sprl_drive_model
	import sprl_pkg::*;
(
	input wire logic aclk,
	output sprl_pkg::sprl_rx_ev_t rx_ev,
	output logic [31:0] rx_word,
	output logic soft_reset_seen,
	output logic drive_busy_bit,
	output logic drive_data_request_bit
);
	// ========
	// idle word toggles so stale data never passes for a frame word
	initial
	begin
		rx_ev = '0;
		rx_word = 32'h0000_0000;
		soft_reset_seen = 1'b0;
		drive_busy_bit = 1'b1;
		drive_data_request_bit = 1'b0;
	end
	task automatic pulse(input sprl_rx_ev_t e);
		@(posedge aclk);
		rx_ev <= e;
		@(posedge aclk);
		rx_ev <= '0;
		rx_word <= ~rx_word;
	endtask
	// status settles through the port's two-flop sync before the frame lands
	task automatic pio(input logic bsy, input logic drq, input logic wr);
		sprl_rx_ev_t e;
		e = '0;
		e.pio_setup = 1'b1;
		e.pio_write = wr;
		@(posedge aclk);
		drive_busy_bit <= bsy;
		drive_data_request_bit <= drq;
		repeat (4) @(posedge aclk);
		pulse(e);
	endtask
	// over-long frames are sent only when a test asks for them
	task automatic frame(input int n, input logic fin);
		sprl_rx_ev_t e;
		e = '0;
		e.reg_word = 1'b1;
		for (int i = 0; i < n; i++)
		begin
			e.reg_end = fin && (i == n - 1);
			@(posedge aclk);
			rx_ev <= e;
			rx_word <= 32'h0000_0100 + 32'(i);
		end
		@(posedge aclk);
		rx_ev <= '0;
		rx_word <= ~rx_word;
	endtask
	// both soft reset frames arrive; the port only sees this level
	task automatic soft_reset();
		@(posedge aclk);
		soft_reset_seen <= 1'b1;
		repeat (4) @(posedge aclk);
		soft_reset_seen <= 1'b0;
	endtask
endmodule

/* File: testbench.sv */
// testbench: register-level checks of port lockup and recovery
// assumes: drive model supplies link events; the bench plays host software
`timescale 1ns/10ps
module testbench;
	import sprl_pkg::*;
	localparam logic [31:0] PSS_M = 32'h0000_0001 << PSS_BIT;
	localparam logic [31:0] IFS_M = 32'h0000_0001 << IFS_BIT;
	localparam logic [31:0] LSE_M = 32'h0000_0001 << LSE_BIT;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic ce = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [31:0] s_axi_rdata, rx_word, rd;
	sprl_rx_ev_t rx_ev, ev;
	logic soft_reset_seen, drive_busy_bit, drive_data_request_bit;
	logic comreset_r, port_stalled_r, irq_r;
	logic tmo;
	int mismatches = 0;
	int comparisons = 0;
	always #2.5 aclk = ~aclk;
	sprl_port i_dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_ev, .rx_word, .soft_reset_seen,
		.drive_busy_bit, .drive_data_request_bit, .comreset_r, .port_stalled_r, .irq_r);
	sprl_drive_model i_drv (.aclk, .rx_ev, .rx_word, .soft_reset_seen, .drive_busy_bit,
		.drive_data_request_bit);
	// ========
	// host access and comparison
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rdr(a);
		chk(rd, e);
		chk(32'(rs), 32'(RESP_OKAY));
	endtask
	task automatic state(input sprl_state_t s);
		rdr(ADDR_STAT);
		chk(32'(rd[1:0]), 32'(s));
	endtask
	// pins are {comreset, stalled, irq}; two edges cover the irq lag
	task automatic pins(input logic [2:0] e);
		repeat (2) @(posedge aclk);
		chk(32'({comreset_r, port_stalled_r, irq_r}), 32'(e));
	endtask
	// host time-out: restarts at each call, expires if the stall never clears
	task automatic host_wait(input int limit, output logic expired);
		int n;
		n = 0;
		while (port_stalled_r === 1'b1 && n < limit)
		begin
			@(posedge aclk);
			n++;
		end
		expired = (n == limit);
	endtask
	task automatic port_reset();
		wr(ADDR_SCTL, 32'h0000_0001);
		pins(3'b100);
		wr(ADDR_SCTL, 32'h0000_0000);
		pins(3'b000);
		state(SPRL_RUN);
		host_wait(16, tmo);
		chk(32'(tmo), 32'h0000_0000);
	endtask
	task automatic end_sim();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ========
	// watchdog: the sequence needs a few thousand cycles at most
	initial
	begin
		#100000;
		mismatches++;
		end_sim();
	end
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rc(ADDR_PIS, ZERO32);
		rc(ADDR_SERR, ZERO32);
		rc(ADDR_SCTL, ZERO32);
		pins(3'b000);
		rdr(8'h1c);
		chk(32'(rs), 32'(RESP_SLVERR));
		wr(8'h40, 32'hffff_ffff);
		chk(32'(rs), 32'(RESP_SLVERR));
		wr(ADDR_PIS_EN, PSS_M);
		// busy only, request only, read setup: flag without a stall
		for (int k = 0; k < 3; k++)
		begin
			i_drv.pio(k == 0, k == 1, k != 2);
			rc(ADDR_TFD, (32'(k == 0) << BSY_BIT) | (32'(k == 1) << DRQ_BIT));
			rc(ADDR_PIS, PSS_M);
			pins(3'b001);
			wr(ADDR_PIS_CLR, PSS_M);
			pins(3'b000);
		end
		wr(ADDR_PIS_EN, ZERO32);
		i_drv.pio(1'b0, 1'b0, 1'b1);
		pins(3'b010);
		rc(ADDR_PIS, PSS_M);
		state(SPRL_STALL_PIO);
		wr(ADDR_PIS_EN, PSS_M);
		pins(3'b011);
		host_wait(16, tmo);
		chk(32'(tmo), 32'h0000_0001);
		// host escalates only when the soft reset fails
		fork
			i_drv.soft_reset();
			begin
				repeat (2) @(posedge aclk);
				rdr(ADDR_STAT);
			end
		join
		chk(32'(rd[5]), 32'h0000_0001);
		wr(ADDR_PIS_CLR, PSS_M);
		pins(3'b010);
		port_reset();
		// sync escape, then a corrupted continue primitive
		for (int k = 0; k < 2; k++)
		begin
			ev = '0;
			ev.sync_escape = (k == 0);
			ev.cont_corrupt = (k == 1);
			i_drv.pulse(ev);
			rc(ADDR_PIS, IFS_M);
			rc(ADDR_SERR, LSE_M);
			state(SPRL_STALL_LINK);
			i_drv.soft_reset();
			pins(3'b010);
			port_reset();
			wr(ADDR_SERR, LSE_M);
			wr(ADDR_PIS_CLR, IFS_M);
			rc(ADDR_SERR, ZERO32);
			rc(ADDR_PIS, ZERO32);
		end
		i_drv.frame(RX_DEPTH, 1'b1);
		pins(3'b000);
		i_drv.frame(RX_DEPTH + 1, 1'b0);
		pins(3'b010);
		rc(ADDR_PIS, 32'h0000_0001 << OVF_BIT);
		state(SPRL_STALL_OVF);
		port_reset();
		end_sim();
	end
endmodule
